// ### tbist_cfg.svh
`ifndef TBIST_CFG_SVH
`define TBIST_CFG_SVH
`define TB_I_SR 8'h03
`define TB_I_STAT 8'h1c
`define TB_I_MASK1 8'h20
`define TB_I_IST1 8'h21
`define TB_I_MASK2 8'h22
`define TB_I_IST2 8'h23
`define TB_I_BITW 8'h24
`define TB_I_TTAG 8'h25
`define TB_I_TREG 8'h28
`define TB_RAM_SEL 18
`define TB_SR_SWRST 0
`define TB_SR_PROTO 7
`define TB_SR_RAM 9
`define TB_SR_CLR 10
`define TB_ST_P_RUN 16'h4800
`define TB_ST_P_PASS 16'ha800
`define TB_ST_P_FAIL 16'h8800
`define TB_ST_R_RUN 16'h4400
`define TB_ST_R_PASS 16'ha400
`define TB_ST_R_FAIL 16'h8400
`define TB_ST_CLR 16'h0000
`define TB_IST2_DONE 1
`define TB_IST1_LOOP 0
`define TB_BITW_FAIL 8
`define TB_N_KEEP 5
`define TB_SCR_BASE 16'h0342
`define TB_SCR_LAST 6'h3b
`define TB_VEC_LAST 4'h7
`define TB_RAM_RD_A 4'h3
`define TB_RAM_CK_A 4'h4
`define TB_RAM_WR_B 4'h5
`define TB_RAM_RD_B 4'h8
`define TB_RAM_LAST 4'h9
`define TB_PAR_AW 12
`define TB_ROM_SEED 16'ha5c3
`define TB_OKAY 2'b00
`define TB_SLVERR 2'b10
`endif

// ### tbist_pkg.sv
`default_nettype none
package tbist_pkg;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_PROTO = 3'b010, ST_RAM = 3'b100} tbist_state_e;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0, MODE_BC = 3'h1, MODE_RT = 3'h2, MODE_MT = 3'h3, MODE_RTMT = 3'h4, MODE_WMON = 3'h5
  } tbist_mode_e;
  typedef logic [15:0] tbist_word_t;
endpackage : tbist_pkg
`default_nettype wire

// ### tbist_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tbist_mem_if #(parameter int AW = 12);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  tbist_pkg::tbist_word_t wdata;
  tbist_pkg::tbist_word_t rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : tbist_mem_if
`default_nettype wire

// ### tbist_ram.sv
`timescale 1ns/1ps
`default_nettype none
module tbist_ram #(
  parameter int AW = 12
)
(
  input wire logic aclk,
  input wire logic aresetn,
  tbist_mem_if.mem port
);
  tbist_pkg::tbist_word_t mem [0:(1<<AW)-1];
  tbist_pkg::tbist_word_t next_rdata;

  always_comb
  begin
    next_rdata = port.rdata;
    if (port.en && !port.we)
    begin
      next_rdata = mem[port.addr];
    end
  end

  // array itself has no reset; contents survive a soft reset
  always_ff @(posedge aclk)
  begin
    if (port.en && port.we)
    begin
      mem[port.addr] <= port.wdata;
    end
    if (!aresetn)
    begin
      port.rdata <= 16'h0000;
    end
    else
    begin
      port.rdata <= next_rdata;
    end
  end
endmodule : tbist_ram
`default_nettype wire

// ### tbist_top.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tbist_cfg.svh"
// Overview of operation
// R1: protocol test starts on hardware reset release
// R2: strap suppresses power-up and requested protocol tests
// R3: software reset never starts the protocol test
// R4: host must not write while tests run
// R5: host write aborts protocol test, no restore
// R6: busy bus controller ignores test requests
// R7: online word monitor ignores test requests
// R8: terminal and monitor modes ignore test starts unless rt halted
// R9: rt failure sets terminal flag, bit word 8
// R10: host waits about 2 ms after power-up
// R11: test end raises enabled interrupt and status
// R12: protocol test applies rom vectors, checks readback
// R13: registers saved before, restored after protocol test
// R14: stack registers clear; time tag keeps counting
// R15: ram kept except 60 scratch words 0342-037d
// R16: old interrupts stay quiet; only completion asserts
// R17: interrupt status restored, completion flag added
// R18: no bus traffic while either test runs
// R19: parity store tested as plain words
// R20: ram gets address then inverted address pattern
// R21: ram contents never restored after ram test
// R22: parity store tested alongside lowest 4k
// R23: online loopback check on every word transmitted in bc or rt mode
// R24: status reads 4800h running, a800h pass, 8800h fail
// R25: bit 7 starts protocol, bit 9 ram test
// R26: bit 10 clears test status to zero
// R27: ram test takes ten clocks per location
// R28: ram test reports status and completion flag
module tbist_top #(
  parameter int RAM_AW = 12,
  parameter bit PARITY = 1'b0,
  parameter int NUM_VEC = 4000
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [19:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [19:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic selftest_disable_strap,
  input wire logic [2:0] term_mode,
  input wire logic term_online,
  input wire logic bc_frame_active,
  input wire logic rt_halted,
  input wire logic [15:0] term_event,
  input wire logic tx_word_valid,
  input wire logic [15:0] tx_word,
  input wire logic [15:0] loop_word,
  output logic irq_n,
  output logic bus_inhibit,
  output logic rt_terminal_flag
);
  typedef tbist_pkg::tbist_word_t word_t;

  tbist_mem_if #(.AW(RAM_AW)) m ();
  tbist_mem_if #(.AW(`TB_PAR_AW)) pm ();

  tbist_ram #(.AW(RAM_AW)) u_ram (.aclk(aclk), .aresetn(aresetn), .port(m.mem));
  generate
    if (PARITY)
    begin : g_par
      tbist_ram #(.AW(`TB_PAR_AW)) u_par (.aclk(aclk), .aresetn(aresetn), .port(pm.mem));
    end
    else
    begin : g_nopar
      assign pm.rdata = 16'h0000;
    end
  endgenerate

  logic [19:0] aw_a, next_aw_a, ar_a, next_ar_a;
  logic aw_h, next_aw_h, w_h, next_w_h, ar_b, next_ar_b, ar_ok, next_ar_ok;
  logic [31:0] w_d, next_w_d, next_rdata;
  logic [3:0] w_s, next_w_s;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  tbist_pkg::tbist_state_e st, next_st;
  logic [15:0] vec, next_vec;
  logic [3:0] ph, next_ph;
  logic [5:0] scr, next_scr;
  logic [RAM_AW-1:0] ra, next_ra;
  logic fail, next_fail, por, next_por, tflag, next_tflag;
  word_t status, next_status, mask1, next_mask1, mask2, next_mask2;
  word_t ist1, next_ist1, ist2, next_ist2, stl1, next_stl1, stl2, next_stl2;
  word_t sv1, next_sv1, sv2, next_sv2, bitw, next_bitw, ttag, next_ttag;
  word_t treg [0:7];
  word_t next_treg [0:7];
  word_t shd [0:7];
  word_t next_shd [0:7];

  logic testing, do_wr, wr_ram, wen, sr_wr, allowed, regv, mis, loop_bad, rd_hit;
  logic [7:0] widx, ridx;
  word_t wd, rom, pa, pb, ev1, rd_word;

  function automatic logic reg_map(input logic [19:0] a);
    logic [7:0] i;
    i = a[9:2];
    reg_map = !a[`TB_RAM_SEL] && (a[17:10] == 8'h00) &&
              (i == `TB_I_SR || i == `TB_I_STAT || (i >= `TB_I_MASK1 && i <= `TB_I_TTAG) ||
               (i & 8'hf8) == `TB_I_TREG);
  endfunction : reg_map

  function automatic logic ram_map(input logic [19:0] a);
    ram_map = a[`TB_RAM_SEL] && ((a[17:2] >> RAM_AW) == 16'h0000);
  endfunction : ram_map

  assign testing = (st != tbist_pkg::ST_IDLE);
  assign bus_inhibit = testing; // R18
  assign do_wr = aw_h && w_h && !bvalid;
  assign awready = !aw_h && !bvalid;
  assign wready = !w_h && !bvalid;
  assign arready = !ar_b && !rvalid && !do_wr;
  assign wr_ram = ram_map(aw_a);
  assign widx = aw_a[9:2];
  assign ridx = ar_a[9:2];
  assign wd = w_d[15:0];
  // registers are 16 bits wide; a write must strobe both low lanes
  assign wen = do_wr && reg_map(aw_a) && (&w_s[1:0]) && !testing;
  assign sr_wr = wen && widx == `TB_I_SR;
  // R6 R7 R8
  assign allowed = (term_mode == tbist_pkg::MODE_IDLE) ||
                   (term_mode == tbist_pkg::MODE_BC && !bc_frame_active) ||
                   (term_mode == tbist_pkg::MODE_WMON && !term_online) ||
                   ((term_mode == tbist_pkg::MODE_RT || term_mode == tbist_pkg::MODE_MT ||
                     term_mode == tbist_pkg::MODE_RTMT) && rt_halted);
  // R23
  assign loop_bad = tx_word_valid && term_online && tx_word != loop_word &&
                    (term_mode == tbist_pkg::MODE_BC || term_mode == tbist_pkg::MODE_RT);
  assign ev1 = term_event | ({15'h0000, loop_bad} << `TB_IST1_LOOP);
  // on-chip vector rom, one word per vector index
  assign rom = vec ^ {vec[7:0], vec[15:8]} ^ `TB_ROM_SEED; // R12
  assign regv = !vec[0];
  assign pa = 16'(ra); // R20
  assign pb = ~pa;
  // R16
  assign irq_n = testing || !(|(ist1 & mask1 & ~stl1) || |(ist2 & mask2 & ~stl2));
  assign rt_terminal_flag = tflag;

  always_comb
  begin
    mis = 1'b0;
    if (st == tbist_pkg::ST_RAM && (ph == `TB_RAM_CK_A || ph == `TB_RAM_LAST))
    begin
      mis = m.rdata != (ph == `TB_RAM_CK_A ? pa : pb);
      if (PARITY && (ra >> `TB_PAR_AW) == '0) // R22
      begin
        mis = mis || pm.rdata != (ph == `TB_RAM_CK_A ? pa : pb); // R19
      end
    end
  end

  always_comb
  begin
    m.en = 1'b0;
    m.we = 1'b0;
    m.addr = aw_a[RAM_AW+1:2];
    m.wdata = wd;
    unique case (st)
      tbist_pkg::ST_IDLE:
      begin
        m.en = (do_wr && wr_ram) || (arvalid && arready && ram_map(araddr));
        m.we = do_wr && wr_ram;
        m.addr = do_wr ? aw_a[RAM_AW+1:2] : araddr[RAM_AW+1:2];
      end
      tbist_pkg::ST_PROTO:
      begin
        m.en = !regv && ph < 4'h2;
        m.we = ph == 4'h0;
        m.addr = RAM_AW'(`TB_SCR_BASE + 16'(scr)); // R15
        m.wdata = rom;
      end
      tbist_pkg::ST_RAM:
      begin
        m.en = ph == 4'h0 || ph == `TB_RAM_RD_A || ph == `TB_RAM_WR_B || ph == `TB_RAM_RD_B;
        m.we = ph == 4'h0 || ph == `TB_RAM_WR_B;
        m.addr = ra;
        m.wdata = ph < `TB_RAM_WR_B ? pa : pb;
      end
      default:
      begin
        m.en = 1'b0;
      end
    endcase
    pm.en = m.en && st == tbist_pkg::ST_RAM && (ra >> `TB_PAR_AW) == '0; // R22
    pm.we = m.we;
    pm.addr = `TB_PAR_AW'(ra);
    pm.wdata = m.wdata;
  end

  always_comb
  begin
    rd_word = 16'h0000;
    rd_hit = reg_map(ar_a);
    if (ram_map(ar_a))
    begin
      rd_hit = ar_ok;
      rd_word = ar_ok ? m.rdata : 16'h0000;
    end
    else if ((ridx & 8'hf8) == `TB_I_TREG)
    begin
      rd_word = treg[ridx[2:0]];
    end
    else
    begin
      unique case (ridx)
        `TB_I_STAT: rd_word = status; // R24
        `TB_I_MASK1: rd_word = mask1;
        `TB_I_IST1: rd_word = ist1;
        `TB_I_MASK2: rd_word = mask2;
        `TB_I_IST2: rd_word = ist2;
        `TB_I_BITW: rd_word = bitw;
        `TB_I_TTAG: rd_word = ttag;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_comb
  begin
    next_aw_h = aw_h;
    next_aw_a = aw_a;
    next_w_h = w_h;
    next_w_d = w_d;
    next_w_s = w_s;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ar_b = 1'b0;
    next_ar_a = ar_a;
    next_ar_ok = ar_ok;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready)
    begin
      next_aw_h = 1'b1;
      next_aw_a = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_h = 1'b1;
      next_w_d = wdata;
      next_w_s = wstrb;
    end
    if (do_wr)
    begin
      next_aw_h = 1'b0;
      next_w_h = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (reg_map(aw_a) || wr_ram) ? `TB_OKAY : `TB_SLVERR;
    end
    else if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_ar_b = 1'b1;
      next_ar_a = araddr;
      next_ar_ok = !testing;
    end
    if (ar_b)
    begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rd_word};
      next_rresp = rd_hit ? `TB_OKAY : `TB_SLVERR;
    end
    else if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_h <= 1'b0;
      aw_a <= 20'h00000;
      w_h <= 1'b0;
      w_d <= 32'h00000000;
      w_s <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `TB_OKAY;
      ar_b <= 1'b0;
      ar_a <= 20'h00000;
      ar_ok <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TB_OKAY;
    end
    else
    begin
      aw_h <= next_aw_h;
      aw_a <= next_aw_a;
      w_h <= next_w_h;
      w_d <= next_w_d;
      w_s <= next_w_s;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ar_b <= next_ar_b;
      ar_a <= next_ar_a;
      ar_ok <= next_ar_ok;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  always_comb
  begin
    logic go_p;
    logic go_r;
    go_p = 1'b0;
    go_r = 1'b0;
    next_st = st;
    next_vec = vec;
    next_ph = ph;
    next_scr = scr;
    next_ra = ra;
    next_fail = fail;
    next_por = por;
    next_status = status;
    next_mask1 = mask1;
    next_mask2 = mask2;
    next_ist1 = ist1;
    next_ist2 = ist2;
    next_stl1 = stl1;
    next_stl2 = stl2;
    next_sv1 = sv1;
    next_sv2 = sv2;
    next_bitw = bitw;
    next_tflag = tflag;
    next_treg = treg;
    next_shd = shd;
    next_ttag = ttag + 16'h0001; // R14
    unique case (st)
      tbist_pkg::ST_IDLE:
      begin
        if (por)
        begin
          next_por = 1'b0;
          go_p = !selftest_disable_strap; // R1 R2
        end
        else if (sr_wr)
        begin
          if (wd[`TB_SR_SWRST]) // R3
          begin
            next_mask1 = 16'h0000;
            next_mask2 = 16'h0000;
            next_ist1 = 16'h0000;
            next_ist2 = 16'h0000;
            next_bitw = 16'h0000;
            next_tflag = 1'b0;
            next_ttag = 16'h0000;
            next_treg = '{default: 16'h0000};
          end
          if (wd[`TB_SR_CLR])
          begin
            next_status = `TB_ST_CLR; // R26
          end
          if (allowed && wd[`TB_SR_PROTO] && wd[`TB_SR_RAM])
          begin
            next_status = `TB_ST_P_FAIL; // both at once cannot pass
          end
          else if (allowed)
          begin
            go_p = wd[`TB_SR_PROTO] && !selftest_disable_strap; // R25 R2
            go_r = wd[`TB_SR_RAM]; // R25
          end
        end
        else if (wen && (widx & 8'hf8) == `TB_I_TREG)
        begin
          next_treg[widx[2:0]] = wd;
        end
        else if (wen && widx == `TB_I_MASK1)
        begin
          next_mask1 = wd;
        end
        else if (wen && widx == `TB_I_MASK2)
        begin
          next_mask2 = wd;
        end
        else if (wen && widx == `TB_I_IST1)
        begin
          next_ist1 = ist1 & ~wd;
          next_stl1 = stl1 & ~wd;
        end
        else if (wen && widx == `TB_I_IST2)
        begin
          next_ist2 = ist2 & ~wd;
          next_stl2 = stl2 & ~wd;
        end
      end
      tbist_pkg::ST_PROTO:
      begin
        if (do_wr)
        begin
          next_st = tbist_pkg::ST_IDLE; // R5
          next_status = `TB_ST_P_FAIL;
          // an aborted test reports failure, so the rt flags follow it
          if (term_mode == tbist_pkg::MODE_RT)
          begin
            next_bitw = bitw | (16'h0001 << `TB_BITW_FAIL); // R9
            next_tflag = 1'b1;
          end
        end
        else
        begin
          if (regv && ph == 4'h0)
          begin
            next_treg[vec[3:1]] = rom; // R12
          end
          if ((regv && ph == 4'h1 && treg[vec[3:1]] != rom) || (!regv && ph == 4'h2 && m.rdata != rom))
          begin
            next_fail = 1'b1; // R12
          end
          next_ph = ph + 4'h1;
          if (ph == `TB_VEC_LAST)
          begin
            next_ph = 4'h0;
            next_vec = vec + 16'h0001;
            if (!regv)
            begin
              next_scr = (scr == `TB_SCR_LAST) ? 6'h00 : scr + 6'h01; // R15
            end
            if (vec == 16'(NUM_VEC - 1))
            begin
              next_st = tbist_pkg::ST_IDLE;
              for (int i = 0; i < 8; i++)
              begin
                next_treg[i] = (i < `TB_N_KEEP) ? shd[i] : 16'h0000; // R13 R14
              end
              next_ist1 = sv1; // R17
              next_ist2 = sv2 | (16'h0001 << `TB_IST2_DONE); // R11 R17
              next_stl1 = sv1; // R16
              next_stl2 = sv2 & ~(16'h0001 << `TB_IST2_DONE);
              next_status = fail ? `TB_ST_P_FAIL : `TB_ST_P_PASS; // R24
              if (fail && term_mode == tbist_pkg::MODE_RT)
              begin
                next_bitw = bitw | (16'h0001 << `TB_BITW_FAIL); // R9
                next_tflag = 1'b1;
              end
            end
          end
        end
      end
      tbist_pkg::ST_RAM:
      begin
        // host writes are dropped here: the port belongs to the test
        next_fail = fail || mis; // R4 R20
        next_ph = ph + 4'h1; // R27
        if (ph == `TB_RAM_LAST)
        begin
          next_ph = 4'h0;
          next_ra = ra + 1'b1;
          if (&ra)
          begin
            next_st = tbist_pkg::ST_IDLE; // R21
            next_status = (fail || mis) ? `TB_ST_R_FAIL : `TB_ST_R_PASS; // R28
            next_ist2 = ist2 | (16'h0001 << `TB_IST2_DONE); // R11 R28
          end
        end
      end
      default:
      begin
        next_st = tbist_pkg::ST_IDLE;
      end
    endcase
    if (go_p || go_r)
    begin
      next_st = go_p ? tbist_pkg::ST_PROTO : tbist_pkg::ST_RAM;
      next_status = go_p ? `TB_ST_P_RUN : `TB_ST_R_RUN; // R24
      next_fail = 1'b0;
      next_vec = 16'h0000;
      next_ph = 4'h0;
      next_ra = '0;
      next_shd = next_treg; // R13
      next_sv1 = next_ist1;
      next_sv2 = next_ist2;
      next_stl1 = next_ist1; // R16
      next_stl2 = next_ist2;
    end
    // set wins over a same-cycle clear
    next_ist1 = next_ist1 | ev1;
    next_stl1 = next_stl1 & ~ev1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= tbist_pkg::ST_IDLE;
      vec <= 16'h0000;
      ph <= 4'h0;
      scr <= 6'h00;
      ra <= '0;
      fail <= 1'b0;
      por <= 1'b1;
      status <= `TB_ST_CLR;
      mask1 <= 16'h0000;
      mask2 <= 16'h0000;
      ist1 <= 16'h0000;
      ist2 <= 16'h0000;
      stl1 <= 16'h0000;
      stl2 <= 16'h0000;
      sv1 <= 16'h0000;
      sv2 <= 16'h0000;
      bitw <= 16'h0000;
      tflag <= 1'b0;
      ttag <= 16'h0000;
      treg <= '{default: 16'h0000};
      shd <= '{default: 16'h0000};
    end
    else
    begin
      st <= next_st;
      vec <= next_vec;
      ph <= next_ph;
      scr <= next_scr;
      ra <= next_ra;
      fail <= next_fail;
      por <= next_por;
      status <= next_status;
      mask1 <= next_mask1;
      mask2 <= next_mask2;
      ist1 <= next_ist1;
      ist2 <= next_ist2;
      stl1 <= next_stl1;
      stl2 <= next_stl2;
      sv1 <= next_sv1;
      sv2 <= next_sv2;
      bitw <= next_bitw;
      tflag <= next_tflag;
      ttag <= next_ttag;
      treg <= next_treg;
      shd <= next_shd;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ram_loc;
    (st == tbist_pkg::ST_RAM && ph != 4'h0) [*8] ##1
    (st == tbist_pkg::ST_RAM && ph == `TB_RAM_LAST) ##1 (ph == 4'h0);
  endsequence

  a_por_start: assert property ($rose(aresetn) && !selftest_disable_strap |-> ##1 st == tbist_pkg::ST_PROTO) // R1
    else $error("no protocol test after reset release");
  a_strap_block: assert property ($rose(st == tbist_pkg::ST_PROTO) |-> !$past(selftest_disable_strap)) // R2
    else $error("protocol test started under strap");
  a_swrst_quiet: assert property (sr_wr && wd[`TB_SR_SWRST] && !wd[`TB_SR_PROTO] && !wd[`TB_SR_RAM] && !por |=> !testing) // R3
    else $error("software reset started a test");
  a_abort_write: assert property (st == tbist_pkg::ST_PROTO && do_wr |=> !testing && status == `TB_ST_P_FAIL) // R5
    else $error("host write did not abort protocol test");
  a_mode_ignore: assert property (sr_wr && !allowed |=> !testing) // R6 R7 R8
    else $error("test started in a forbidden mode");
  a_rt_fail_flag: assert property ($fell(testing) && status == `TB_ST_P_FAIL && term_mode == tbist_pkg::MODE_RT |-> bitw[`TB_BITW_FAIL] && tflag) // R9
    else $error("rt failure not flagged");
  a_run_status: assert property (st == tbist_pkg::ST_PROTO |-> status == `TB_ST_P_RUN) // R24
    else $error("running status wrong");
  a_irq_quiet: assert property (testing |-> irq_n) // R16
    else $error("interrupt asserted during test");
  a_clr_status: assert property (sr_wr && wd[`TB_SR_CLR] && !wd[`TB_SR_PROTO] && !wd[`TB_SR_RAM] && !por |=> status == 16'h0000) // R26
    else $error("status not cleared");
  a_ram_pace: assert property (st == tbist_pkg::ST_RAM && ph == 4'h0 |=> s_ram_loc) // R27
    else $error("ram location not ten clocks");
  a_done_flag: assert property ($fell(testing) && !$past(do_wr) |-> ist2[`TB_IST2_DONE]) // R11 R28
    else $error("completion flag missing");
  a_ttag_runs: assert property (testing ##1 testing |-> ttag == $past(ttag) + 16'h0001) // R14
    else $error("time tag stalled during test");
endmodule : tbist_top
`default_nettype wire

// ### tbist_host.sv
`timescale 1ns/1ps
`default_nettype none
module tbist_host (
  input wire logic aclk,
  output logic [19:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [19:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial
  begin
    {awaddr, awvalid, wvalid, araddr, arvalid, wdata} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
  end
  task automatic wr(input logic [19:0] a, input logic [15:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    join
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [19:0] a, output logic [15:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata[15:0];
    r = rresp;
  endtask : rd
endmodule : tbist_host
`default_nettype wire

// ### terminal_builtin_self_test_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbist_cfg.svh"
module terminal_builtin_self_test_tb;
  localparam int AW = 10;
  localparam int NV = 16;
  // idle bc wmon rt mt rtmt
  localparam logic [2:0] MD [6] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h4};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic selftest_disable_strap = 1'b0;
  logic [2:0] term_mode = 3'h0;
  logic term_online = 1'b0;
  logic bc_frame_active = 1'b0;
  logic rt_halted = 1'b0;
  logic tx_word_valid = 1'b0;
  logic [15:0] term_event = '0;
  logic [15:0] tx_word = '0;
  logic [15:0] loop_word = '0;
  logic [19:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic irq_n, bus_inhibit, rt_terminal_flag;
  logic [15:0] d, t0, dv [4];
  logic [9:0] ad [4];
  int errors = 0;
  int n_checks = 0;
  int n;
  always #2.5 aclk = ~aclk;
  tbist_top #(.RAM_AW(AW), .PARITY(1'b1), .NUM_VEC(NV)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .selftest_disable_strap, .term_mode, .term_online, .bc_frame_active, .rt_halted,
    .term_event, .tx_word_valid, .tx_word, .loop_word, .irq_n, .bus_inhibit, .rt_terminal_flag);
  tbist_host u_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  function automatic logic [19:0] ra(input logic [7:0] i);
    return {10'h000, i, 2'b00};
  endfunction : ra
  function automatic logic [19:0] ma(input logic [9:0] i);
    return {8'h40, i, 2'b00};
  endfunction : ma
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic w(input logic [19:0] a, input logic [15:0] v);
    u_host.wr(a, v, rs);
  endtask : w
  task automatic rc(input string nm, input logic [19:0] a, input logic [15:0] e);
    logic [15:0] v;
    u_host.rd(a, v, rs);
    chk(nm, e, v);
  endtask : rc
  // polling only reads; a write here would abort the test
  task automatic wait_done();
    do u_host.rd(ra(`TB_I_STAT), d, rs); while (d === 16'h4800);
  endtask : wait_done
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    void'($urandom(32'h0af7));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("inh", 16'h0001, 16'(bus_inhibit));
    rc("st", ra(`TB_I_STAT), 16'h4800);
    wait_done();
    rc("st", ra(`TB_I_STAT), 16'ha800);
    w(ra(`TB_I_MASK1), 16'h0008);
    w(ra(`TB_I_MASK2), 16'h0002);
    w(ra(8'h2d), 16'h5a5a);
    w(ra(8'h28), 16'hc3c3);
    term_event <= 16'h0008;
    @(posedge aclk) term_event <= 16'h0000;
    ad = '{10'h341, 10'h37e, 10'h000, 10'($urandom % 32'h341)};
    for (int k = 0; k < 4; k++)
    begin
      dv[k] = 16'($urandom);
      w(ma(ad[k]), dv[k]);
    end
    chk("irq", 16'h0000, 16'(irq_n));
    u_host.rd(ra(`TB_I_TTAG), t0, rs);
    w(ra(`TB_I_SR), 16'h0080);
    repeat (2) @(posedge aclk);
    chk("inh", 16'h0001, 16'(bus_inhibit));
    chk("irq", 16'h0001, 16'(irq_n));
    wait_done();
    rc("st", ra(`TB_I_STAT), 16'ha800);
    for (int k = 0; k < 4; k++)
      rc("ram", ma(ad[k]), dv[k]);
    rc("ist1", ra(`TB_I_IST1), 16'h0008);
    rc("ist2", ra(`TB_I_IST2), 16'h0002);
    chk("irq", 16'h0000, 16'(irq_n));
    rc("msk1", ra(`TB_I_MASK1), 16'h0008);
    rc("stk", ra(8'h2d), 16'h0000);
    rc("treg", ra(8'h28), 16'hc3c3);
    u_host.rd(ra(`TB_I_TTAG), d, rs);
    chk("ttag", 16'h0001, 16'(d - t0 > 16'(NV * 8)));
    w(ra(`TB_I_IST2), 16'h0002);
    chk("irq", 16'h0001, 16'(irq_n));
    w(ra(`TB_I_SR), 16'h0400);
    rc("st", ra(`TB_I_STAT), 16'h0000);
    term_mode <= 3'h2;
    rt_halted <= 1'b1;
    w(ra(`TB_I_SR), 16'h0080);
    w(ma(10'h010), 16'h1234);
    rc("st", ra(`TB_I_STAT), 16'h8800);
    chk("tflag", 16'h0001, 16'(rt_terminal_flag));
    rc("bitw", ra(`TB_I_BITW), 16'h0100);
    w(ra(`TB_I_SR), 16'h0001);
    repeat (2) @(posedge aclk);
    chk("inh", 16'h0000, 16'(bus_inhibit));
    rc("st", ra(`TB_I_STAT), 16'h8800);
    d = 16'($urandom);
    term_mode <= 3'h1;
    term_online <= 1'b1;
    rt_halted <= 1'b0;
    tx_word <= d;
    loop_word <= ~d;
    tx_word_valid <= 1'b1;
    @(posedge aclk) tx_word_valid <= 1'b0;
    rc("ist1", ra(`TB_I_IST1), 16'h0001);
    w(ra(`TB_I_SR), 16'h0400);
    for (int i = 0; i < 6; i++)
    begin
      selftest_disable_strap <= (i == 0);
      term_mode <= MD[i];
      bc_frame_active <= 1'b1;
      w(ra(`TB_I_SR), (i % 2) ? 16'h0200 : 16'h0080);
      repeat (2) @(posedge aclk);
      chk("inh", 16'h0000, 16'(bus_inhibit));
      rc("st", ra(`TB_I_STAT), 16'h0000);
    end
    // strap left high: it must not block the ram test
    selftest_disable_strap <= 1'b1;
    term_mode <= 3'h0;
    term_online <= 1'b0;
    bc_frame_active <= 1'b0;
    w(ra(`TB_I_SR), 16'h0200);
    n = 0;
    while (bus_inhibit === 1'b1 && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("cyc", 16'h0001, 16'(n > 10 * 2 ** AW - 8 && n <= 10 * 2 ** AW));
    rc("st", ra(`TB_I_STAT), 16'ha400);
    rc("ist2", ra(`TB_I_IST2), 16'h0002);
    for (int k = 0; k < 10; k++)
    begin
      ad[0] = (k < 2) ? 10'(k * 1023) : 10'($urandom);
      rc("pat", ma(ad[0]), ~{6'h00, ad[0]});
    end
    u_host.rd(20'h41000, d, rs);
    chk("rresp", 16'h0002, 16'(rs));
    end_of_test();
  end
  initial
  begin
    repeat (40000) @(posedge aclk);
    errors++;
    end_of_test();
  end
endmodule : terminal_builtin_self_test_tb
`default_nettype wire
